// [logic/csx_pkg.sv]
package csx_pkg;

    // ------------------------------------------------------------------
    // Clock and widths
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ     = 40_000_000;
    localparam int unsigned INSTR_W    = 12;
    localparam int unsigned PC_W       = 11;
    localparam int unsigned BANK_W     = 3;
    localparam int unsigned FADDR_W    = 5;
    localparam int unsigned STACK_LVLS = 4;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_INSTR  = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_OPTION = 8'h08;
    localparam logic [7:0] REG_PC     = 8'h0C;
    localparam logic [7:0] REG_CYCLES = 8'h10;
    localparam logic [7:0] REG_STACK  = 8'h14;

    // ------------------------------------------------------------------
    // Status field positions and the instruction destination bit
    // ------------------------------------------------------------------
    localparam int unsigned ST_ACC_LSB  = 0;
    localparam int unsigned ST_ZERO_BIT = 8;
    localparam int unsigned ST_GIE_BIT  = 9;
    localparam int unsigned ST_BUSY_BIT = 10;
    localparam int unsigned ST_BANK_LSB = 12;
    localparam int unsigned INSTR_D_BIT = 5;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]        RST_ACC    = 8'h00;
    localparam logic [7:0]        RST_OPTION = 8'hFF;
    localparam logic [PC_W-1:0]   RST_PC     = 11'h000;
    localparam logic [BANK_W-1:0] RST_BANK   = 3'h0;
    localparam logic [INSTR_W-1:0] RST_INSTR = 12'h000;

    // ------------------------------------------------------------------
    // Instruction encodings: match under mask
    // ------------------------------------------------------------------
    localparam logic [11:0] MSK_FULL   = 12'hFFF;
    localparam logic [11:0] MSK_BYTE   = 12'hFC0;
    localparam logic [11:0] MSK_LIT8   = 12'hF00;
    localparam logic [11:0] MSK_STORE  = 12'hFE0;
    localparam logic [11:0] MSK_BANK   = 12'hFF8;
    localparam logic [11:0] ENC_OPTION = 12'h002;
    localparam logic [11:0] ENC_RETIRQ = 12'h00F;
    localparam logic [11:0] ENC_SETBNK = 12'h010;
    localparam logic [11:0] ENC_STORE  = 12'h020;
    localparam logic [11:0] ENC_ORFILE = 12'h100;
    localparam logic [11:0] ENC_LDFILE = 12'h200;
    localparam logic [11:0] ENC_INCR_FILE_OP   = 12'h280;
    localparam logic [11:0] ENC_INCR_SKIP_ZERO_OP = 12'h3C0;
    localparam logic [11:0] ENC_CALL   = 12'h900;
    localparam logic [11:0] ENC_LDIMM  = 12'hC00;
    localparam logic [11:0] ENC_ORIMM  = 12'hD00;

    // ------------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_EXEC  = 4'b0100,
        ST_EXTRA = 4'b1000
    } csx_state_e;

    typedef enum logic [3:0] {
        OP_NOP, OP_INCR_FILE_OP, OP_INCR_SKIP_ZERO_OP, OP_ORIMM, OP_ORFILE, OP_STORE, OP_LDFILE,
        OP_SETBNK, OP_OPTION, OP_LDIMM, OP_RETIRQ, OP_CALL
    } csx_op_e;

endpackage

// [logic/csx_mem_if.sv]
`timescale 1ns/1ps
interface csx_mem_if #(
    parameter int unsigned AW = 8,
    parameter int unsigned DW = 8
);
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;

    modport core (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
    modport mem  (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

// [logic/csx_file_mem.sv]
`timescale 1ns/1ps
module csx_file_mem #(
    parameter int unsigned AW = 8,
    parameter int unsigned DW = 8
) (
    input wire logic   clk,
    input wire logic   rst_n,
    csx_mem_if.mem     mp
);
    logic [DW-1:0] mem_q [2**AW];
    logic [DW-1:0] rd_data_ff;

    // Storage has no reset; only the read register is cleared
    always_ff @(posedge clk)
    begin
        if (mp.wr_en)
        begin
            mem_q[mp.wr_addr] <= mp.wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_ff <= '0;
        end
        else
        begin
            rd_data_ff <= mem_q[mp.rd_addr];
        end
    end

    assign mp.rd_data = rd_data_ff;
endmodule

// [logic/csx_core.sv]
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// How it works
// RULE1 - Increment adds one to file operand, result to destination, zero flag updated.
// RULE2 - Increment-skip writes result, flags untouched; zero result skips next, two cycles.
// RULE3 - OR-immediate ORs accumulator with 8-bit literal into accumulator, zero flag updated.
// RULE4 - OR-file ORs accumulator with file operand into destination, zero flag updated.
// RULE5 - Store copies accumulator into addressed file register, flags untouched.
// RULE6 - Load-file copies operand to destination, zero flag updated; acts as zero test.
// RULE7 - Destination bit 0 sends result to accumulator, 1 back to file register.
// RULE8 - Set-bank loads 3-bit literal into bank select, flags untouched.
// RULE9 - Load-configuration copies accumulator into prescale configuration, flags untouched.
// RULE10 - Load-immediate puts 8-bit literal into accumulator, flags untouched.
// RULE11 - Return-from-interrupt loads PC from top of stack, two cycles, flags untouched.
// RULE12 - Return-from-interrupt also sets the global interrupt enable bit.
// RULE13 - Call pushes PC plus one onto the stack for a later return.
// RULE14 - Instructions without branch or skip complete in one instruction cycle.
// RULE15 - Zero flag set when flag-affecting result is zero, cleared otherwise.
module csx_core #(
    parameter int unsigned STACK_DEPTH = csx_pkg::STACK_LVLS
) (
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY
);
    localparam int unsigned SP_W = $clog2(STACK_DEPTH);
    localparam int unsigned MA_W = csx_pkg::BANK_W + csx_pkg::FADDR_W;

    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic hits(input logic [11:0] ins, input logic [11:0] msk,
                                  input logic [11:0] enc);
        return (ins & msk) == enc;
    endfunction

    function automatic logic null_of(input logic [7:0] v);
        return v == 8'h00;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    csx_pkg::csx_state_e           state_ff;
    csx_pkg::csx_op_e              op;
    logic [csx_pkg::INSTR_W-1:0]   instr_ff;
    logic [7:0]                    acc_ff;
    logic                          zero_ff;
    logic                          gie_ff;
    logic [csx_pkg::BANK_W-1:0]    bank_ff;
    logic [7:0]                    option_ff;
    logic [csx_pkg::PC_W-1:0]      pc_ff;
    logic [csx_pkg::PC_W-1:0]      stack_ff [STACK_DEPTH];
    logic [SP_W-1:0]               sp_ff;
    logic [31:0]                   cycles_ff;
    logic [7:0]                    aw_addr_ff;
    logic [31:0]                   w_data_ff;
    logic [3:0]                    w_strb_ff;
    logic                          aw_held_ff;
    logic                          w_held_ff;
    logic                          bvalid_ff;
    logic [1:0]                    bresp_ff;
    logic                          rvalid_ff;
    logic [31:0]                   rdata_ff;
    logic [1:0]                    rresp_ff;

    logic                          wr_fire;
    logic                          idle;
    logic                          issue;
    logic                          exec_now;
    logic [7:0]                    operand;
    logic [7:0]                    incr;
    logic [7:0]                    result;
    logic                          to_acc;
    logic                          to_file;
    logic                          upd_zero;
    logic                          branch;
    logic                          dest_file;
    logic                          wr_known;
    logic [31:0]                   rd_mux;
    logic                          rd_known;
    logic [31:0]                   status_word;
    logic [31:0]                   stat_merged;
    logic [31:0]                   instr_merged;
    logic [31:0]                   pc_merged;

    csx_mem_if #(.AW(MA_W), .DW(8)) mem_bus ();

    csx_file_mem #(.AW(MA_W), .DW(8)) u_mem (
        .clk   (SYS_CLK),
        .rst_n (NRST),
        .mp    (mem_bus.mem)
    );

    // ------------------------------------------------------------------
    // Bus slave: write address and data taken independently
    // ------------------------------------------------------------------
    assign AWREADY = !aw_held_ff;
    assign WREADY  = !w_held_ff;
    assign BVALID  = bvalid_ff;
    assign BRESP   = bresp_ff;
    assign ARREADY = !rvalid_ff;
    assign RVALID  = rvalid_ff;
    assign RDATA   = rdata_ff;
    assign RRESP   = rresp_ff;
    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
    assign idle    = state_ff == csx_pkg::ST_IDLE;
    // Instruction writes while busy are dropped, not queued
    assign issue   = wr_fire && idle && aw_addr_ff == csx_pkg::REG_INSTR;

    always_comb
    begin
        wr_known = 1'b1;
        unique case (aw_addr_ff)
            csx_pkg::REG_INSTR, csx_pkg::REG_STATUS, csx_pkg::REG_PC: wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff  <= 32'h0000_0000;
            w_strb_ff  <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= csx_pkg::RESP_OKAY;
        end
        else
        begin
            if (AWVALID && !aw_held_ff)
            begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= {AWADDR[7:2], 2'b00};
            end
            if (WVALID && !w_held_ff)
            begin
                w_held_ff <= 1'b1;
                w_data_ff <= WDATA;
                w_strb_ff <= WSTRB;
            end
            if (wr_fire)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_known ? csx_pkg::RESP_OKAY : csx_pkg::RESP_SLVERR;
            end
            if (bvalid_ff && BREADY)
            begin
                bvalid_ff  <= 1'b0;
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
            end
        end
    end

    assign status_word = {17'h0, bank_ff, 1'b0, !idle, gie_ff, zero_ff, acc_ff};
    // Strobed register writes merge into the current value a byte at a time
    assign stat_merged  = strb_merge(status_word, w_data_ff, w_strb_ff);
    assign instr_merged = strb_merge({20'h0, instr_ff}, w_data_ff, w_strb_ff);
    assign pc_merged    = strb_merge({21'h0, pc_ff}, w_data_ff, w_strb_ff);

    always_comb
    begin
        rd_mux   = 32'h0000_0000;
        rd_known = 1'b1;
        unique case ({ARADDR[7:2], 2'b00})
            csx_pkg::REG_INSTR:  rd_mux = {20'h0, instr_ff};
            csx_pkg::REG_STATUS: rd_mux = status_word;
            csx_pkg::REG_OPTION: rd_mux = {24'h0, option_ff};
            csx_pkg::REG_PC:     rd_mux = {21'h0, pc_ff};
            csx_pkg::REG_CYCLES: rd_mux = cycles_ff;
            csx_pkg::REG_STACK:  rd_mux = 32'(sp_ff);
            default:             rd_known = 1'b0;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= csx_pkg::RESP_OKAY;
        end
        else if (ARVALID && !rvalid_ff)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_mux;
            rresp_ff  <= rd_known ? csx_pkg::RESP_OKAY : csx_pkg::RESP_SLVERR;
        end
        else if (rvalid_ff && RREADY)
        begin
            rvalid_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Decode and execute
    // ------------------------------------------------------------------
    always_comb
    begin
        op = csx_pkg::OP_NOP;
        if (hits(instr_ff, csx_pkg::MSK_FULL, csx_pkg::ENC_OPTION))      op = csx_pkg::OP_OPTION;
        else if (hits(instr_ff, csx_pkg::MSK_FULL, csx_pkg::ENC_RETIRQ)) op = csx_pkg::OP_RETIRQ;
        else if (hits(instr_ff, csx_pkg::MSK_BANK, csx_pkg::ENC_SETBNK)) op = csx_pkg::OP_SETBNK;
        else if (hits(instr_ff, csx_pkg::MSK_STORE, csx_pkg::ENC_STORE)) op = csx_pkg::OP_STORE;
        else if (hits(instr_ff, csx_pkg::MSK_BYTE, csx_pkg::ENC_ORFILE)) op = csx_pkg::OP_ORFILE;
        else if (hits(instr_ff, csx_pkg::MSK_BYTE, csx_pkg::ENC_LDFILE)) op = csx_pkg::OP_LDFILE;
        else if (hits(instr_ff, csx_pkg::MSK_BYTE, csx_pkg::ENC_INCR_FILE_OP))   op = csx_pkg::OP_INCR_FILE_OP;
        else if (hits(instr_ff, csx_pkg::MSK_BYTE, csx_pkg::ENC_INCR_SKIP_ZERO_OP)) op = csx_pkg::OP_INCR_SKIP_ZERO_OP;
        else if (hits(instr_ff, csx_pkg::MSK_LIT8, csx_pkg::ENC_CALL))   op = csx_pkg::OP_CALL;
        else if (hits(instr_ff, csx_pkg::MSK_LIT8, csx_pkg::ENC_LDIMM))  op = csx_pkg::OP_LDIMM;
        else if (hits(instr_ff, csx_pkg::MSK_LIT8, csx_pkg::ENC_ORIMM))  op = csx_pkg::OP_ORIMM;
    end

    // File operand is banked: bank select forms the upper address bits
    assign mem_bus.rd_addr = {bank_ff, instr_ff[csx_pkg::FADDR_W-1:0]};
    assign operand         = mem_bus.rd_data;
    assign incr            = 8'(operand + 8'h01);
    assign dest_file       = instr_ff[csx_pkg::INSTR_D_BIT];
    assign exec_now        = state_ff == csx_pkg::ST_EXEC;

    always_comb
    begin
        result   = 8'h00;
        to_acc   = 1'b0;
        to_file  = 1'b0;
        upd_zero = 1'b0;
        branch   = 1'b0;
        unique case (op)
            csx_pkg::OP_INCR_FILE_OP:   begin result = incr; upd_zero = 1'b1; end       // [RULE1]
            csx_pkg::OP_INCR_SKIP_ZERO_OP: begin result = incr; branch = null_of(incr); end // [RULE2]
            csx_pkg::OP_ORIMM:  begin result = acc_ff | instr_ff[7:0]; to_acc = 1'b1;
                                      upd_zero = 1'b1; end                      // [RULE3]
            csx_pkg::OP_ORFILE: begin result = acc_ff | operand; upd_zero = 1'b1; end // [RULE4]
            csx_pkg::OP_STORE:  begin result = acc_ff; to_file = 1'b1; end       // [RULE5]
            csx_pkg::OP_LDFILE: begin result = operand; upd_zero = 1'b1; end     // [RULE6]
            csx_pkg::OP_LDIMM:  begin result = instr_ff[7:0]; to_acc = 1'b1; end // [RULE10]
            csx_pkg::OP_RETIRQ, csx_pkg::OP_CALL: branch = 1'b1;               // [RULE11]
            csx_pkg::OP_NOP, csx_pkg::OP_SETBNK, csx_pkg::OP_OPTION: ;
        endcase
        if (op inside {csx_pkg::OP_INCR_FILE_OP, csx_pkg::OP_INCR_SKIP_ZERO_OP, csx_pkg::OP_ORFILE,
                       csx_pkg::OP_LDFILE})
        begin
            to_acc  = !dest_file;                                              // [RULE7]
            to_file = dest_file;                                               // [RULE7]
        end
    end

    assign mem_bus.wr_en   = exec_now && to_file;
    assign mem_bus.wr_addr = mem_bus.rd_addr;
    assign mem_bus.wr_data = result;

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_ff <= csx_pkg::ST_IDLE;
            instr_ff <= csx_pkg::RST_INSTR;
        end
        else
        begin
            unique case (state_ff)
                csx_pkg::ST_IDLE:
                begin
                    if (issue)
                    begin
                        instr_ff <= instr_merged[csx_pkg::INSTR_W-1:0];
                        state_ff <= csx_pkg::ST_FETCH;
                    end
                end
                csx_pkg::ST_FETCH: state_ff <= csx_pkg::ST_EXEC;
                // Branches and taken skips spend a second instruction cycle
                csx_pkg::ST_EXEC:  state_ff <= branch ? csx_pkg::ST_EXTRA
                                                      : csx_pkg::ST_IDLE; // [RULE14] [RULE2]
                csx_pkg::ST_EXTRA: state_ff <= csx_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            cycles_ff <= 32'h0000_0000;
        end
        else if (exec_now || state_ff == csx_pkg::ST_EXTRA)
        begin
            cycles_ff <= cycles_ff + 32'h0000_0001;                          // [RULE14]
        end
    end

    // Accumulator, zero flag, bank and configuration
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            acc_ff    <= csx_pkg::RST_ACC;
            zero_ff   <= 1'b0;
            bank_ff   <= csx_pkg::RST_BANK;
            option_ff <= csx_pkg::RST_OPTION;
        end
        else if (exec_now)
        begin
            if (to_acc)
            begin
                acc_ff <= result;
            end
            if (upd_zero)
            begin
                zero_ff <= null_of(result);                                  // [RULE15]
            end
            if (op == csx_pkg::OP_SETBNK)
            begin
                bank_ff <= instr_ff[csx_pkg::BANK_W-1:0];                    // [RULE8]
            end
            if (op == csx_pkg::OP_OPTION)
            begin
                option_ff <= acc_ff;                                         // [RULE9]
            end
        end
        else if (idle && wr_fire && aw_addr_ff == csx_pkg::REG_STATUS)
        begin
            acc_ff  <= stat_merged[7:0];
            zero_ff <= stat_merged[csx_pkg::ST_ZERO_BIT];
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            gie_ff <= 1'b0;
        end
        else if (exec_now && op == csx_pkg::OP_RETIRQ)
        begin
            gie_ff <= 1'b1;                                                  // [RULE12]
        end
        else if (idle && wr_fire && aw_addr_ff == csx_pkg::REG_STATUS)
        begin
            gie_ff <= stat_merged[csx_pkg::ST_GIE_BIT];
        end
    end

    // Program counter and stack; stack wraps when overfilled, no error is raised
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pc_ff <= csx_pkg::RST_PC;
            sp_ff <= '0;
            for (int i = 0; i < STACK_DEPTH; i++)
            begin
                stack_ff[i] <= csx_pkg::RST_PC;
            end
        end
        else if (exec_now)
        begin
            unique case (op)
                csx_pkg::OP_CALL:
                begin
                    stack_ff[sp_ff] <= csx_pkg::PC_W'(pc_ff + 1'b1);         // [RULE13]
                    sp_ff           <= SP_W'(sp_ff + 1'b1);
                    pc_ff           <= {pc_ff[10:9], 1'b0, instr_ff[7:0]};
                end
                csx_pkg::OP_RETIRQ:
                begin
                    pc_ff <= stack_ff[SP_W'(sp_ff - 1'b1)];                  // [RULE11]
                    sp_ff <= SP_W'(sp_ff - 1'b1);
                end
                // Skip steps over the already fetched next word
                csx_pkg::OP_INCR_SKIP_ZERO_OP: pc_ff <= csx_pkg::PC_W'(pc_ff + (branch ? 2 : 1)); // [RULE2]
                default:            pc_ff <= csx_pkg::PC_W'(pc_ff + 1'b1);
            endcase
        end
        else if (idle && wr_fire && aw_addr_ff == csx_pkg::REG_PC)
        begin
            pc_ff <= pc_merged[csx_pkg::PC_W-1:0];
        end
    end
endmodule

// [tb/csx_core_sva.sv]
`timescale 1ns/1ps
module csx_core_sva (
    input wire logic       SYS_CLK,
    input wire logic       NRST,
    input wire logic [7:0] AWADDR,
    input wire logic       AWVALID,
    input wire logic       AWREADY,
    input wire logic       WVALID,
    input wire logic       WREADY,
    input wire logic [1:0] BRESP,
    input wire logic       BVALID,
    input wire logic       BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic       ARVALID,
    input wire logic       ARREADY,
    input wire logic [1:0] RRESP,
    input wire logic       RVALID,
    input wire logic       RREADY
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    AST_B_HOLD: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write answer dropped early");
    AST_R_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RRESP))
        else $error("read answer dropped early");
    AST_R_ANS: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
        else $error("read not answered");
    AST_W_ANS: assert property (AWVALID && AWREADY && WVALID && WREADY
        |=> !AWREADY && !WREADY ##1 BVALID) else $error("write not answered");
    AST_B_END: assert property (BVALID && BREADY |=> !BVALID && AWREADY && WREADY)
        else $error("write answer not retired");
    AST_R_END: assert property (RVALID && RREADY |=> !RVALID && ARREADY)
        else $error("read answer not retired");
    AST_UNMAP: assert property (ARVALID && ARREADY && ARADDR[7:2] > 6'h05
        |=> RRESP == csx_pkg::RESP_SLVERR) else $error("unmapped read accepted");
    AST_OPT_RO: assert property (AWVALID && AWREADY && WVALID && WREADY
        && AWADDR[7:2] == 6'h02 |=> ##1 BVALID && BRESP == csx_pkg::RESP_SLVERR)
        else $error("read-only write accepted");
endmodule
bind csx_core csx_core_sva u_csx_core_sva (.*);

// [tb/csx_core_tb_top.sv]
`timescale 1ns/1ps
module csx_core_tb_top;
    logic        SYS_CLK = 0, NRST = 0, AWVALID = 0, WVALID = 0, BREADY = 0;
    logic        ARVALID = 0, RREADY = 0, AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, RDATA, rd, n;
    logic [3:0]  WSTRB = 4'hF;
    logic [1:0]  BRESP, RRESP, rs;
    int          n_errors = 0, comparisons = 0, cyc = 0;

    csx_core u_csx_core (.*);

    always #12.5 SYS_CLK = ~SYS_CLK;

    // Ceiling well above the few hundred cycles the tests need
    always @(posedge SYS_CLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors = n_errors + 1;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    // Settled answers are sampled at the falling edge, released after the next rise;
    // ready rises only once the answer is seen, so the slave must hold it a cycle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tr, fin, seen;
        @(posedge SYS_CLK);
        AWADDR  <= a;
        ARADDR  <= a;
        WDATA   <= d;
        AWVALID <= w;
        WVALID  <= w;
        ARVALID <= !w;
        fin = 0;
        while (!fin)
        begin
            @(negedge SYS_CLK);
            ta  = AWVALID && AWREADY;
            tw  = WVALID && WREADY;
            tr  = ARVALID && ARREADY;
            fin = (BVALID && BREADY) || (RVALID && RREADY);
            seen = w ? BVALID : RVALID;
            rd  = RDATA;
            rs  = w ? BRESP : RRESP;
            @(posedge SYS_CLK);
            if (ta) AWVALID <= 1'b0;
            if (tw) WVALID <= 1'b0;
            if (tr) ARVALID <= 1'b0;
            if (seen && !fin)
            begin
                BREADY <= w;
                RREADY <= !w;
            end
        end
        BREADY <= 1'b0;
        RREADY <= 1'b0;
    endtask

    // Leaves the final status word in rd
    task automatic exec(input logic [11:0] i);
        xfer(1, csx_pkg::REG_INSTR, {20'h0, i});
        do xfer(0, csx_pkg::REG_STATUS, 0);
        while (rd[csx_pkg::ST_BUSY_BIT] !== 1'b0);
    endtask

    task automatic t_acc();
        xfer(0, csx_pkg::REG_CYCLES, 0);
        n = rd;
        exec(12'hC00);
        chk("ldi0", 32'h0, rd[9:0]);
        exec(12'hD00);
        chk("ori0", 32'h100, rd[9:0]);
        exec(12'hDA5);
        chk("oriA5", 32'hA5, rd[9:0]);
        exec(12'hC00);
        chk("ldi_keep", 32'h0, rd[9:0]);
        exec(12'h000);
        chk("nop", 32'h0, rd[9:0]);
        xfer(0, csx_pkg::REG_CYCLES, 0);
        chk("cycles", n + 5, rd);
        $display("t_acc done");
    endtask

    task automatic t_file();
        exec(12'h017);
        chk("bank", 32'h7, rd[14:12]);
        exec(12'hCFF);
        exec(12'h023);
        chk("store", 32'hFF, rd[9:0]);
        exec(12'h2A3);
        chk("inc_f", 32'h1FF, rd[9:0]);
        exec(12'h203);
        chk("ld_w", 32'h100, rd[9:0]);
        exec(12'h283);
        chk("inc_w", 32'h1, rd[9:0]);
        exec(12'hC80);
        exec(12'h123);
        exec(12'hC00);
        exec(12'h223);
        chk("ztest", 32'h0, rd[9:0]);
        exec(12'h203);
        chk("or_f", 32'h80, rd[9:0]);
        $display("t_file done");
    endtask

    task automatic t_flow();
        exec(12'hCFF);
        exec(12'h024);
        xfer(0, csx_pkg::REG_PC, 0);
        n = rd;
        exec(12'h3C4);
        chk("skip_w", 32'h0, rd[9:0]);
        xfer(0, csx_pkg::REG_PC, 0);
        chk("skip_pc", n + 2, rd);
        xfer(1, csx_pkg::REG_PC, 32'h605);
        xfer(0, csx_pkg::REG_CYCLES, 0);
        n = rd;
        exec(12'h940);
        xfer(0, csx_pkg::REG_STACK, 0);
        chk("push", 32'h1, rd);
        exec(12'h00F);
        chk("gie", 32'h200, rd[9:0]);
        xfer(0, csx_pkg::REG_PC, 0);
        chk("ret_pc", 32'h606, rd);
        xfer(0, csx_pkg::REG_CYCLES, 0);
        chk("br_cyc", n + 4, rd);
        $display("t_flow done");
    endtask

    task automatic t_opt();
        xfer(0, csx_pkg::REG_OPTION, 0);
        chk("opt_rst", 32'hFF, rd);
        exec(12'hC3C);
        exec(12'h002);
        xfer(0, csx_pkg::REG_OPTION, 0);
        chk("opt", 32'h3C, rd);
        xfer(1, csx_pkg::REG_OPTION, 0);
        chk("opt_ro", csx_pkg::RESP_SLVERR, rs);
        xfer(0, 8'h40, 0);
        chk("unmapped", csx_pkg::RESP_SLVERR, rs);
        $display("t_opt done");
    endtask

    task automatic results();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge SYS_CLK);
        chk("rst_out", 32'h7, {BVALID, RVALID, AWREADY, WREADY, ARREADY});
        NRST <= 1'b1;
        t_acc();
        t_file();
        t_flow();
        t_opt();
        results();
    end
endmodule
